// ==== src/sgps_pkg.sv ====
// sgps_pkg: constants, field layouts and carrier types of the setting group selector.
// assumes one pclk domain; used by sgps_selector and sgps_evfifo.
package sgps_pkg;
  localparam int NGRP = 8;
  localparam int NEV = 30;
  localparam int EVQ_DEPTH = 8;
  localparam int EVQ_AW = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REQ = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK_ON = 8'h0C;
  localparam logic [7:0] OFS_MASK_OFF = 8'h10;
  localparam logic [7:0] OFS_EV_HEAD = 8'h14;
  localparam logic [7:0] OFS_EV_STAMP = 8'h18;
  localparam logic [7:0] OFS_TIME = 8'h1C;

  // field positions
  localparam int CTRL_FEN_BIT = 0;
  localparam int CTRL_FGRP_LSB = 4;
  localparam int CTRL_USED_LSB = 8;
  localparam int REQ_REM_LSB = 0;
  localparam int REQ_LOC_LSB = 4;

  // reset values and write masks
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_07F1;
  localparam logic [31:0] MASK_RST = 32'h3FFF_FFFF;

  // event indices inside the condition vector
  localparam int EV_ENA = 0;
  localparam int EV_REQ = 8;
  localparam int EV_ACT = 16;
  localparam int EV_REM = 24;
  localparam int EV_LOC = 25;
  localparam int EV_FRC = 26;
  localparam int EV_NCFG = 27;
  localparam int EV_FFAIL = 28;
  localparam int EV_LPRI = 29;
  // after reset only group one is enabled and active
  localparam logic [29:0] COND_RST = 30'h0001_0001;

  typedef struct packed {
    logic on;
    logic [4:0] code;
    logic [31:0] stamp;
  } sgps_event_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } sgps_apb_req_t;

  // lowest set bit: {found, index}
  function automatic logic [5:0] sgps_first(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // bits 0..n set: the group and every group of higher priority
  function automatic logic [7:0] sgps_upto(input logic [2:0] n);
    return 8'hFF >> (3'h7 - n);
  endfunction

  // group code 1..8 is configured when it lies within the used range
  function automatic logic sgps_cfg_ok(input logic [3:0] code, input logic [2:0] used_idx);
    return (code != 4'h0) && (code <= ({1'b0, used_idx} + 4'h1));
  endfunction
endpackage

// ==== src/sgps_evfifo.sv ====
// sgps_evfifo: event buffer holding time-stamped events until software pops them.
// assumes pclk domain; writer stalls on in_ready low.
module sgps_evfifo (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire sgps_pkg::sgps_event_t in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output sgps_pkg::sgps_event_t out_data
);
  import sgps_pkg::*;

  sgps_event_t mem_q [EVQ_DEPTH];
  logic [EVQ_AW-1:0] wptr_q;
  logic [EVQ_AW-1:0] rptr_q;
  logic [EVQ_AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != 4'(EVQ_DEPTH));
  assign out_valid = (cnt_q != 4'h0);
  assign out_data = mem_q[rptr_q];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wptr_q <= wptr_q + 3'(push);
      rptr_q <= rptr_q + 3'(pop);
      cnt_q <= cnt_q + 4'(push) - 4'(pop);
    end
  end
endmodule

// ==== src/sgps_selector.sv ====
// sgps_selector: picks the active one of eight parameter groups, logs time-stamped events.
// assumes an apb master on pclk and group request pins from outside the clock domain.
// Operation
// R1: eight requests ranked by fixed priority, group one highest, eight lowest.
// R2: a request may be a short pulse or a held level; both count.
// R3: a held group one request blocks every other request.
// R4: a held request of groups two to seven blocks all lower groups.
// R5: a held group eight request blocks nothing.
// R6: no automatic return to group one; active group stays until requested.
// R7: dropping a held group one falls back to a held group two.
// R8: outside logic drives group one from coil status for fail-safe fallback.
// R9: every status change of enable, request, active and flags raises an event.
// R10: per event, ON, OFF or both transitions are stored.
// R11: each stored event carries the time of its status change.
// R12: remote, local and forced change give separate ON and OFF events.
// R13: requests to unconfigured groups are refused with a failure event; no not-configured or lower-priority failure event is raised while force enable is set.
// R14: an unhonourable forced change raises a force failure event pair.
// R15: requests refused by a held higher group raise a lower-priority failure.
// R16: a pulse-activated group stays active until another group is requested; here a held lower group retakes control when the pulse ends.
// R17: force enable overrides automatic control; held levels retake it on release.
// R18: remote change cannot pick a lower group while a higher one is held.
// R19: used-groups count limits groups to one up to count; default one.
// R20: simultaneous requests activate the highest-priority configured group; a remote command beats a local one in the same write, whatever their priority.
// R21: a refused request leaves the active group unchanged; a pin request refused below a held group reselects the highest held group.
module sgps_selector (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire sgps_pkg::sgps_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // group request pins, bit 0 is group one
  input wire logic [7:0] grp_req,
  // active group, one-hot
  output logic [7:0] grp_active
);
  import sgps_pkg::*;

  // apb decode
  wire setup = apb_req.psel && !apb_req.penable;
  wire access = apb_req.psel && apb_req.penable;
  wire [7:0] addr = apb_req.paddr;
  wire hit = (addr == OFS_CTRL) || (addr == OFS_REQ) || (addr == OFS_STATUS) || (addr == OFS_MASK_ON) ||
             (addr == OFS_MASK_OFF) || (addr == OFS_EV_HEAD) || (addr == OFS_EV_STAMP) || (addr == OFS_TIME);
  wire wr = access && apb_req.pwrite && hit;
  wire wr_ctrl = wr && (addr == OFS_CTRL);
  wire wr_req = wr && (addr == OFS_REQ);
  wire wr_mon = wr && (addr == OFS_MASK_ON);
  wire wr_moff = wr && (addr == OFS_MASK_OFF);
  wire wr_pop = wr && (addr == OFS_EV_HEAD);
  wire [3:0] wr_rem = apb_req.pwdata[REQ_REM_LSB +: 4];
  wire [3:0] wr_loc = apb_req.pwdata[REQ_LOC_LSB +: 4];

  logic [31:0] ctrl_q;
  logic [31:0] mask_on_q;
  logic [31:0] mask_off_q;
  logic [31:0] prdata_q;
  logic [31:0] time_q;
  logic [7:0] req_s1_q;
  logic [7:0] req_s_q;
  logic [7:0] req_prev_q;
  logic force_prev_q;
  logic rem_go_q;
  logic loc_go_q;
  logic [3:0] rem_code_q;
  logic [3:0] loc_code_q;
  logic [2:0] active_q;
  logic [2:0] active_d;
  logic ncfg_q;
  logic lpri_q;
  logic ffail_q;
  logic [29:0] cond_prev_q;
  logic [29:0] pend_q;
  logic [29:0] pend_on_q;
  logic [31:0] stamp_q [NEV];

  // control fields
  wire force_en = ctrl_q[CTRL_FEN_BIT];
  wire [3:0] force_code = ctrl_q[CTRL_FGRP_LSB +: 4];
  wire [2:0] used_idx = ctrl_q[CTRL_USED_LSB +: 3];
  wire [7:0] used_mask = sgps_upto(used_idx); // [R19]
  wire force_ok = sgps_cfg_ok(force_code, used_idx);
  wire [2:0] force_idx = 3'(force_code - 4'h1);
  wire force_fall = force_prev_q && !force_en;

  // held levels; a pulse is a level that is short, so both read alike [R2]
  wire [7:0] held = req_s_q & used_mask;
  wire [7:0] req_rise = req_s_q & ~req_prev_q;
  wire req_chg = (held != (req_prev_q & used_mask));
  wire [5:0] top_f = sgps_first({24'h0, held}); // [R1] [R20]
  wire top_found = top_f[5];
  wire [2:0] top_idx = top_f[2:0];

  // software change commands; remote beats local in the same cycle
  wire cmd_go = rem_go_q || loc_go_q;
  wire [3:0] cmd_code = rem_go_q ? rem_code_q : loc_code_q;
  wire cmd_cfg = sgps_cfg_ok(cmd_code, used_idx);
  wire [2:0] cmd_idx = 3'(cmd_code - 4'h1);
  wire [7:0] cmd_higher = sgps_upto(cmd_idx) & ~(8'h01 << cmd_idx);
  wire cmd_blocked = |(held & cmd_higher); // [R18]
  wire auto_run = !force_en && !force_fall && !req_chg;

  // failures: pins rising or commands naming unused groups, or below a held group
  wire pin_ncfg = !force_en && |(req_rise & ~used_mask);
  wire pin_lpri = !force_en && top_found && |(req_rise & used_mask & ~sgps_upto(top_idx)); // [R4] [R5]
  wire cmd_ncfg = auto_run && cmd_go && !cmd_cfg;
  wire cmd_lpri = auto_run && cmd_go && cmd_cfg && cmd_blocked;

  // selection: force first, then changes of held levels, then commands
  always_comb begin
    active_d = active_q; // [R6] [R16] [R21]
    if (force_en) begin
      if (force_ok) begin
        active_d = force_idx; // [R17]
      end
    end else if ((force_fall || req_chg) && top_found) begin
      active_d = top_idx; // [R3] [R4] [R7] [R17]
    end else if (auto_run && cmd_go && cmd_cfg && !cmd_blocked) begin
      active_d = cmd_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1_q <= 8'h00;
      req_s_q <= 8'h00;
      req_prev_q <= 8'h00;
      force_prev_q <= 1'b0;
      active_q <= 3'h0;
      ncfg_q <= 1'b0;
      lpri_q <= 1'b0;
      ffail_q <= 1'b0;
      time_q <= 32'h0000_0000;
    end else begin
      req_s1_q <= grp_req;
      req_s_q <= req_s1_q;
      req_prev_q <= req_s_q;
      force_prev_q <= force_en;
      active_q <= active_d;
      ncfg_q <= pin_ncfg || cmd_ncfg; // [R13]
      lpri_q <= pin_lpri || cmd_lpri; // [R15]
      ffail_q <= force_en && !force_ok; // [R14]
      time_q <= time_q + 32'h0000_0001;
    end
  end

  // registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      mask_on_q <= MASK_RST;
      mask_off_q <= MASK_RST;
      rem_go_q <= 1'b0;
      loc_go_q <= 1'b0;
      rem_code_q <= 4'h0;
      loc_code_q <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= apb_req.pwdata & CTRL_WMASK;
      end
      if (wr_mon) begin
        mask_on_q <= apb_req.pwdata & MASK_RST;
      end
      if (wr_moff) begin
        mask_off_q <= apb_req.pwdata & MASK_RST;
      end
      rem_go_q <= wr_req && (wr_rem != 4'h0);
      loc_go_q <= wr_req && (wr_loc != 4'h0);
      if (wr_req) begin
        rem_code_q <= wr_rem;
        loc_code_q <= wr_loc;
      end
    end
  end

  // monitored conditions; a change in any of them is an event
  wire [7:0] act_onehot = 8'h01 << active_q;
  wire [29:0] cond = {lpri_q, ffail_q, ncfg_q, force_en, loc_go_q, rem_go_q, act_onehot, req_s_q, used_mask}; // [R12]
  wire [29:0] chg = cond ^ cond_prev_q; // [R9]
  wire [29:0] keep = chg & ((cond & mask_on_q[29:0]) | (~cond & mask_off_q[29:0])); // [R10]

  // one pending slot per event; the lowest index drains first
  wire [5:0] pend_f = sgps_first({2'b00, pend_q});
  wire [4:0] drain_idx = pend_f[4:0];
  logic fifo_ready;
  wire push = pend_f[5] && fifo_ready;
  wire [29:0] drain_clr = push ? (30'h0000_0001 << drain_idx) : 30'h0000_0000;
  sgps_event_t ev_in;
  assign ev_in.on = pend_on_q[drain_idx];
  assign ev_in.code = drain_idx;
  assign ev_in.stamp = stamp_q[drain_idx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_prev_q <= COND_RST;
      pend_q <= 30'h0000_0000;
      pend_on_q <= 30'h0000_0000;
    end else begin
      cond_prev_q <= cond;
      // a new change wins over the drain of the same slot
      pend_q <= (pend_q & ~drain_clr) | keep;
      pend_on_q <= (pend_on_q & ~keep) | (cond & keep);
    end
  end

  // stamp taken in the cycle the change is seen
  always_ff @(posedge pclk) begin
    for (int i = 0; i < NEV; i++) begin
      if (keep[i]) begin
        stamp_q[i] <= time_q; // [R11]
      end
    end
  end

  // a slow reader stalls draining; a slot changing twice meanwhile keeps only its latest edge
  logic ev_ovalid;
  sgps_event_t ev_out;
  sgps_evfifo sgps_evfifo_i (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(pend_f[5]),
    .in_ready(fifo_ready),
    .in_data(ev_in),
    .out_valid(ev_ovalid),
    .out_ready(wr_pop),
    .out_data(ev_out)
  );

  // read mux, captured in the setup cycle so that prdata comes from a flop
  wire [31:0] rd_status = {8'h00, used_mask, held, 5'h00, active_q};
  wire [31:0] rd_head = {ev_ovalid, 22'h00_0000, ev_out.on, 3'h0, ev_out.code};
  wire [31:0] rd_mux = (addr == OFS_CTRL) ? ctrl_q :
                       (addr == OFS_STATUS) ? rd_status :
                       (addr == OFS_MASK_ON) ? mask_on_q :
                       (addr == OFS_MASK_OFF) ? mask_off_q :
                       (addr == OFS_EV_HEAD) ? rd_head :
                       (addr == OFS_EV_STAMP) ? (ev_ovalid ? ev_out.stamp : 32'h0000_0000) :
                       (addr == OFS_TIME) ? time_q : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign grp_active = act_onehot;

  // checks
  chk_force_sel: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    (force_en && force_ok) |=> (active_q == $past(force_idx)))
    else $error("forced group not taken");
  chk_group_one_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (held[0] && !force_en && $past(held[0]) && $past(active_q) == 3'h0) |=> (active_q == 3'h0))
    else $error("held group one lost");
  chk_lower_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (auto_run && cmd_go && cmd_cfg && top_found && (cmd_idx > top_idx)) |=> (lpri_q && $stable(active_q)))
    else $error("lower request not refused");
  chk_notcfg_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (auto_run && cmd_go && !cmd_cfg) |=> (ncfg_q && $stable(active_q)))
    else $error("unconfigured request not refused");
  chk_pulse_keeps: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    (auto_run && !cmd_go) |=> $stable(active_q))
    else $error("active group moved without request");
  chk_fall_back: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (!force_en && !force_fall && $fell(held[0]) && held[1]) |=> (active_q == 3'h1))
    else $error("no fallback to group two");
  chk_force_fail: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    (force_en && !force_ok) [*2] |=> (ffail_q && !cond_prev_q[EV_FFAIL] == 1'b0))
    else $error("force failure not flagged");
  chk_prio_pick: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    (!force_en && req_chg && top_found) |=> (active_q == $past(top_idx)) ##1 (act_onehot[active_q]))
    else $error("highest held group not chosen");
  chk_event_pend: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    (keep != 30'h0000_0000) |=> ((pend_q & $past(keep)) == $past(keep)))
    else $error("event change not pending");
  chk_mask_off: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (chg[EV_FRC] && !cond[EV_FRC] && !mask_off_q[EV_FRC] && !pend_q[EV_FRC]) |=> !pend_q[EV_FRC])
    else $error("masked off edge stored");
  // a command that passes every gate must land; a refused force must not move the group
  chk_cmd_take: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (auto_run && cmd_go && cmd_cfg && !cmd_blocked) |=> (active_q == $past(cmd_idx)))
    else $error("accepted command not applied");
  chk_force_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    (force_en && !force_ok) |=> $stable(active_q))
    else $error("refused force moved the group");
  chk_force_fall: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    (force_fall && top_found) |=> (active_q == $past(top_idx)))
    else $error("held level did not retake control");
  chk_lpri_pin: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    (!force_en && held[0] && used_mask[2] && $rose(req_s_q[2])) |=> lpri_q)
    else $error("request under held group one not flagged");
  // the slot must keep the count of the change cycle, not of the later drain
  chk_stamp_time: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    keep[EV_LPRI] |=> (stamp_q[EV_LPRI] == $past(time_q)))
    else $error("event stamp not the change time");
endmodule

// ==== bench/sgps_pins.sv ====
// sgps_pins: stands in for relay logic and digital inputs that drive the group request pins.
// assumes the bench changes lvl, pulse_grp and pulse_go just after rising pclk edges.
module sgps_pins (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic [7:0] lvl,
  input wire logic [7:0] pulse_grp,
  input wire logic pulse_go,
  // request pins, bit 0 is group one
  output logic [7:0] grp_req
);
  logic [1:0] cnt_q;
  logic [7:0] pls_q;

  // a pulse lasts three cycles, one more than the synchroniser needs, so it is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      pls_q <= 8'h00;
    end else if (pulse_go) begin
      cnt_q <= 2'h3;
      pls_q <= pulse_grp;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // bit 0 follows the coil-connected status: a broken wire reads low and group two takes over
  assign grp_req = lvl | ((cnt_q != 2'h0) ? pls_q : 8'h00);
endmodule

// ==== bench/tb_setting_group_priority_selector.sv ====
// tb_setting_group_priority_selector: directed checks of the group selector over apb and pins.
// assumes sgps_pkg and sgps_selector compiled first; sgps_pins drives the request pins.
module tb_setting_group_priority_selector;
  timeunit 1ns;
  timeprecision 1ps;
  import sgps_pkg::*;

  logic pclk;
  logic presetn;
  sgps_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] grp_req;
  logic [7:0] grp_active;
  logic [7:0] lvl;
  logic [7:0] pulse_grp;
  logic pulse_go;
  logic [31:0] rq;
  logic re;
  logic [31:0] t0;
  logic [31:0] t1;
  int fails;
  int num_checks;

  sgps_selector sgps_selector_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .grp_req(grp_req), .grp_active(grp_active));
  sgps_pins sgps_pins_i (.pclk(pclk), .presetn(presetn), .lvl(lvl), .pulse_grp(pulse_grp),
    .pulse_go(pulse_go), .grp_req(grp_req));

  always #25 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rq, re);
    chk(nm, exp, rq);
  endtask

  // the active group moves three edges after a pin edge; eight leaves margin
  task automatic act(input logic [7:0] exp);
    repeat (8) @(posedge pclk);
    chk("grp_active", {24'h000000, exp}, {24'h000000, grp_active});
  endtask

  task automatic set_lvl(input logic [7:0] v);
    @(posedge pclk);
    lvl <= v;
  endtask

  task automatic pulse(input logic [7:0] g);
    @(posedge pclk);
    pulse_grp <= g;
    pulse_go <= 1'b1;
    @(posedge pclk);
    pulse_go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic drain();
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, OFS_EV_HEAD, 32'h0000_0000, rq, re);
      if (rq[31] !== 1'b1) begin
        break;
      end
      wr(OFS_EV_HEAD, 32'h0000_0000);
    end
  endtask

  task automatic head(input logic [31:0] exp);
    repeat (4) @(posedge pclk);
    rd_chk("ev_head", OFS_EV_HEAD, exp);
    wr(OFS_EV_HEAD, 32'h0000_0000);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    lvl = 8'h00;
    pulse_grp = 8'h00;
    pulse_go = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    act(8'h01);
    rd_chk("ctrl", OFS_CTRL, CTRL_RST);
    rd_chk("mask_on", OFS_MASK_ON, MASK_RST);
    rd_chk("mask_off", OFS_MASK_OFF, MASK_RST);
    rd_chk("ev_head", OFS_EV_HEAD, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000, rq, re);
    chk("pslverr", 32'h0000_0001, {31'h00000000, re});
    // enabling group two logs one ON event stamped inside the write
    apb(1'b0, OFS_TIME, 32'h0000_0000, t0, re);
    wr(OFS_CTRL, 32'h0000_0100);
    apb(1'b0, OFS_TIME, 32'h0000_0000, t1, re);
    rd_chk("ev_head", OFS_EV_HEAD, 32'h8000_0101);
    apb(1'b0, OFS_EV_STAMP, 32'h0000_0000, rq, re);
    chk("stamp in range", 32'h0000_0001, {31'h00000000, (rq >= t0 && rq <= t1)});
    wr(OFS_EV_HEAD, 32'h0000_0000);
    rd_chk("ev_head", OFS_EV_HEAD, 32'h0000_0000);
    // only the OFF edge of the remote flag is kept
    wr(OFS_MASK_ON, 32'h0000_0000);
    wr(OFS_MASK_OFF, 32'h0100_0000);
    wr(OFS_REQ, 32'h0000_0002);
    act(8'h02);
    head(32'h8000_0018);
    // from here only the failure flags' ON edges are stored
    wr(OFS_MASK_ON, 32'h3800_0000);
    wr(OFS_MASK_OFF, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0700);
    drain();
    pulse(8'h04);
    act(8'h04);
    repeat (20) @(posedge pclk);
    act(8'h04);
    set_lvl(8'h0A);
    act(8'h02);
    rd_chk("status", OFS_STATUS, 32'h00FF_0A01);
    drain();
    pulse(8'h10);
    act(8'h02);
    head(32'h8000_011D);
    set_lvl(8'h03);
    act(8'h01);
    pulse(8'h04);
    act(8'h01);
    set_lvl(8'h02);
    act(8'h02);
    set_lvl(8'h80);
    act(8'h80);
    // a pulse here would hand control back to the held group eight when it ends
    set_lvl(8'hA0);
    act(8'h20);
    set_lvl(8'h04);
    act(8'h04);
    wr(OFS_REQ, 32'h0000_0005);
    act(8'h04);
    wr(OFS_REQ, 32'h0000_0002);
    act(8'h02);
    wr(OFS_REQ, 32'h0000_0060);
    act(8'h02);
    wr(OFS_REQ, 32'h0000_0010);
    act(8'h01);
    set_lvl(8'h00);
    // only groups one and two configured
    wr(OFS_CTRL, 32'h0000_0100);
    drain();
    wr(OFS_REQ, 32'h0000_0004);
    act(8'h01);
    head(32'h8000_011B);
    pulse(8'h40);
    act(8'h01);
    wr(OFS_CTRL, 32'h0000_0121);
    act(8'h02);
    pulse(8'h01);
    act(8'h02);
    drain();
    wr(OFS_CTRL, 32'h0000_0151);
    act(8'h02);
    head(32'h8000_011C);
    set_lvl(8'h01);
    wr(OFS_CTRL, 32'h0000_0100);
    act(8'h01);
    tally_and_finish();
  end
endmodule
